// ==== common/cta_defs.svh ====
`ifndef CTA_DEFS_SVH
`define CTA_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_COUNTER_CONTROL 8'hD8
`define IDX_COUNTER_MODE    8'hD9
`define IDX_MODULE_MODE0    8'hDA
`define IDX_COUNT_LO        8'hE0
`define IDX_COUNT_HI        8'hE1
`define IDX_IRQ_MASK        8'hE2

// counter_control fields
`define CTRL_OVF_BIT        7
`define CTRL_RUN_BIT        6
`define CTRL_FLAG_MASK      8'h9F

// counter_mode fields
`define MODE_IDLE_BIT       7
`define MODE_WDOG_BIT       6
`define MODE_SEL_LSB        1
`define MODE_OVFIE_BIT      0
`define MODE_WR_MASK        8'hC7

// module mode fields
`define MM_IE_BIT           0
`define MM_PWM_BIT          1
`define MM_TOG_BIT          2
`define MM_MATCH_BIT        3
`define MM_CAPN_BIT         4
`define MM_CAPP_BIT         5
`define MM_COMP_BIT         6
`define MM_WR_MASK          8'h7F

// reset values
`define COUNTER_MODE_RST    8'h00
`define COUNTER_CTRL_RST    8'h00
`define MODULE_MODE_RST     8'h00
`define IRQ_MASK_RST        8'hFF

// prescale divisors in oscillator cycles
`define DIV_SLOW            12
`define DIV_SLOW_X2         6
`define DIV_FAST            4
`define DIV_FAST_X2         2

// port 1 pin positions
`define ECI_PIN             2
`define MODULE_PIN_BASE     3

`endif

// ==== common/cta_pkg.sv ====
package cta_pkg;
  typedef enum logic [1:0] {SRC_DIV12, SRC_DIV4, SRC_T0, SRC_EXT} src_sel_t;
  typedef logic [7:0] byte_t;
endpackage

// ==== common/tick_if.sv ====
`timescale 1ns/1ps
interface tick_if;
  import cta_pkg::*;
  src_sel_t srcSel;
  logic     doubleSpeed;
  logic     enable;
  logic     t0Pulse;
  logic     eciPulse;
  logic     tick;
  modport ctrl (output srcSel, doubleSpeed, enable, t0Pulse, eciPulse, input tick);
  modport gen  (input srcSel, doubleSpeed, enable, t0Pulse, eciPulse, output tick);
endinterface

// ==== src/edge_pulse.sv ====
`timescale 1ns/1ps
module edge_pulse #(
  parameter bit RISING = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic din,
  output logic      pulse
);
  logic [2:0] sync_ff;
  logic       pulse_ff;

  // two-stage synchroniser plus one history stage; stage 0 feeds stage 1 only
  always_ff @(posedge ref_clk) begin
    if (!rstn) sync_ff <= 3'h0;
    else       sync_ff <= {sync_ff[1:0], din};
  end

  // one-cycle pulse per selected edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) pulse_ff <= 1'b0;
    else       pulse_ff <= RISING ? (sync_ff[1] & ~sync_ff[2]) : (~sync_ff[1] & sync_ff[2]);
  end

  assign pulse = pulse_ff;
endmodule // edge_pulse

// ==== src/count_prescaler.sv ====
`timescale 1ns/1ps
`include "cta_defs.svh"
module count_prescaler #(
  parameter int DIV_W = 4
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  tick_if.gen       tk
);
  import cta_pkg::*;

  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic [DIV_W-1:0] divLast;
  logic             internalSrc;
  logic             wrap;

  // divisor per source, halved in double-speed mode
  always_comb begin
    if (tk.srcSel == SRC_DIV12)
      divLast = tk.doubleSpeed ? DIV_W'(`DIV_SLOW_X2 - 1) : DIV_W'(`DIV_SLOW - 1);
    else
      divLast = tk.doubleSpeed ? DIV_W'(`DIV_FAST_X2 - 1) : DIV_W'(`DIV_FAST - 1);
  end

  assign internalSrc = (tk.srcSel == SRC_DIV12) || (tk.srcSel == SRC_DIV4);
  // >= so a switch to a shorter divisor mid-count cannot overrun
  assign wrap        = div_ff >= divLast;

  // divider held at zero while stopped, so a restart gives a full period
  always_comb begin
    nxt_div = div_ff;
    if (!tk.enable || !internalSrc) nxt_div = '0;
    else if (wrap)                  nxt_div = '0;
    else                            nxt_div = div_ff + DIV_W'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) div_ff <= '0;
    else       div_ff <= nxt_div;
  end

  // one count enable per source event
  always_comb begin
    case (tk.srcSel)
      SRC_DIV12, SRC_DIV4: tk.tick = tk.enable & wrap;
      SRC_T0:              tk.tick = tk.enable & tk.t0Pulse;
      SRC_EXT:             tk.tick = tk.enable & tk.eciPulse;
      default:             tk.tick = 1'b0;
    endcase
  end
endmodule // count_prescaler

// ==== src/counter_array_time_base.sv ====
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "cta_defs.svh"
module counter_array_time_base #(
  parameter int NUM_MOD = 5
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  input  wire logic [9:0]                   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [7:0]                   p1In,
  input  wire logic [7:0]                   gpioOut,
  input  wire logic [7:0]                   gpioOeN,
  output logic      [7:0]                   p1Out,
  output logic      [7:0]                   p1OeN,
  input  wire logic                         timer0Ovf,
  input  wire logic                         idleMode,
  input  wire logic                         doubleSpeed,
  input  wire logic [NUM_MOD-1:0]           moduleEvent,
  input  wire logic [NUM_MOD-1:0]           moduleOut,
  output cta_pkg::byte_t [NUM_MOD-1:0]      moduleMode,
  output logic      [15:0]                  countValue,
  output logic                              watchdogEnable,
  output logic                              irq
);
  import cta_pkg::*;

  tick_if tk ();

  logic [7:0]               idx;
  logic                     wrAcc;
  logic                     rdSetup;
  logic                     hit;
  logic [7:0]               rdByte;
  logic [7:0]               counterMode_ff;
  logic                     ovf_ff;
  logic                     run_ff;
  logic [NUM_MOD-1:0]       modFlag_ff;
  byte_t [NUM_MOD-1:0]      modMode_ff;
  logic [7:0]               irqMask_ff;
  logic [15:0]              count_ff;
  logic [31:0]              prdata_ff;
  logic                     irq_ff;
  logic [7:0]               p1Out_ff;
  logic [7:0]               p1OeN_ff;
  logic [7:0]               nxt_p1Out;
  logic [7:0]               nxt_p1OeN;
  logic                     ctrlWr;
  logic                     loWr;
  logic                     hiWr;
  logic                     ovfEvent;
  logic [NUM_MOD-1:0]       modIe;
  logic                     irqReq;

  // apb decode; zero wait states, so every access completes in its first access cycle
  assign idx     = paddr[9:2];
  assign wrAcc   = psel & penable & pwrite;
  assign rdSetup = psel & ~penable & ~pwrite;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign ctrlWr  = wrAcc && (idx == `IDX_COUNTER_CONTROL);
  assign loWr    = wrAcc && (idx == `IDX_COUNT_LO);
  assign hiWr    = wrAcc && (idx == `IDX_COUNT_HI);

  // read mux; reserved and unimplemented bits read zero, except mask bits 6:5, which read one from reset until the first mask write
  always_comb begin
    rdByte = 8'h00;
    hit    = 1'b0;
    if (idx == `IDX_COUNTER_CONTROL) begin
      rdByte = {ovf_ff, run_ff, 1'b0, modFlag_ff};
      hit    = 1'b1;
    end
    if (idx == `IDX_COUNTER_MODE) begin
      rdByte = counterMode_ff;
      hit    = 1'b1;
    end
    if (idx == `IDX_COUNT_LO) begin
      rdByte = count_ff[7:0];
      hit    = 1'b1;
    end
    if (idx == `IDX_COUNT_HI) begin
      rdByte = count_ff[15:8];
      hit    = 1'b1;
    end
    if (idx == `IDX_IRQ_MASK) begin
      rdByte = irqMask_ff;
      hit    = 1'b1;
    end
    for (int i = 0; i < NUM_MOD; i++) begin
      if (idx == 8'(`IDX_MODULE_MODE0 + i)) begin
        rdByte = modMode_ff[i];
        hit    = 1'b1;
      end
    end
  end

  // read data captured in the setup phase, held through the access phase
  always_ff @(posedge ref_clk) begin
    if (!rstn)        prdata_ff <= 32'h0000_0000;
    else if (rdSetup) prdata_ff <= {24'h00_0000, rdByte};
  end
  assign prdata = prdata_ff;

  // mode register; reserved bits never stored, so stray ones are harmless
  always_ff @(posedge ref_clk) begin
    if (!rstn) counterMode_ff <= `COUNTER_MODE_RST;
    else if (wrAcc && idx == `IDX_COUNTER_MODE)
      counterMode_ff <= pwdata[7:0] & `MODE_WR_MASK;
  end
  assign watchdogEnable = counterMode_ff[`MODE_WDOG_BIT];

  // per-module mode registers, decoded by the module datapaths
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_MOD; i++) modMode_ff[i] <= `MODULE_MODE_RST;
    end else begin
      for (int i = 0; i < NUM_MOD; i++) begin
        if (wrAcc && idx == 8'(`IDX_MODULE_MODE0 + i))
          modMode_ff[i] <= pwdata[7:0] & `MM_WR_MASK;
      end
    end
  end
  assign moduleMode = modMode_ff;

  // interrupt mask, all open after reset
  always_ff @(posedge ref_clk) begin
    if (!rstn) irqMask_ff <= `IRQ_MASK_RST;
    else if (wrAcc && idx == `IDX_IRQ_MASK) irqMask_ff <= pwdata[7:0] & `CTRL_FLAG_MASK;
  end

  // run control is an ordinary read/write bit
  always_ff @(posedge ref_clk) begin
    if (!rstn)       run_ff <= 1'(`COUNTER_CTRL_RST >> `CTRL_RUN_BIT);
    else if (ctrlWr) run_ff <= pwdata[`CTRL_RUN_BIT];
  end

  // count enable: running and not parked by idle-stop
  assign tk.enable      = run_ff & ~(counterMode_ff[`MODE_IDLE_BIT] & idleMode);
  assign tk.srcSel      = src_sel_t'(counterMode_ff[`MODE_SEL_LSB +: 2]);
  assign tk.doubleSpeed = doubleSpeed;

  // count inputs go through synchronisers to one-cycle pulses
  edge_pulse #(.RISING(1'b1)) u_t0_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (timer0Ovf),
    .pulse   (tk.t0Pulse)
  );

  // external input counted on falling edges; pin rate must stay below osc/8
  edge_pulse #(.RISING(1'b0)) u_eci_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (p1In[`ECI_PIN]),
    .pulse   (tk.eciPulse)
  );

  count_prescaler #(.DIV_W(4)) u_presc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tk      (tk)
  );

  // shared time base; a software byte write beats a tick in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn)        count_ff <= 16'h0000;
    else if (loWr)    count_ff[7:0] <= pwdata[7:0];
    else if (hiWr)    count_ff[15:8] <= pwdata[7:0];
    else if (tk.tick) count_ff <= count_ff + 16'h0001;
  end
  assign countValue = count_ff;

  assign ovfEvent = tk.tick && !loWr && !hiWr && (count_ff == 16'hFFFF);

  // flags are write-one-to-clear; a set in the same cycle wins over the clear
  always_ff @(posedge ref_clk) begin
    if (!rstn) ovf_ff <= 1'b0;
    else       ovf_ff <= (ovf_ff & ~(ctrlWr & pwdata[`CTRL_OVF_BIT])) | ovfEvent;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) modFlag_ff <= '0;
    else modFlag_ff <= (modFlag_ff & ~({NUM_MOD{ctrlWr}} & pwdata[NUM_MOD-1:0]))
                       | moduleEvent;
  end

  // one shared request: overflow gated by its enable, modules by their own
  always_comb begin
    for (int i = 0; i < NUM_MOD; i++) modIe[i] = modMode_ff[i][`MM_IE_BIT];
  end
  assign irqReq = (ovf_ff & counterMode_ff[`MODE_OVFIE_BIT] & irqMask_ff[`CTRL_OVF_BIT])
                | (|(modFlag_ff & modIe & irqMask_ff[NUM_MOD-1:0]));

  always_ff @(posedge ref_clk) begin
    if (!rstn) irq_ff <= 1'b0;
    else       irq_ff <= irqReq;
  end
  assign irq = irq_ff;

  // port 1 sharing: modules drive when toggling or modulating, float when capturing
  always_comb begin
    nxt_p1Out = gpioOut;
    nxt_p1OeN = gpioOeN;
    if (tk.srcSel == SRC_EXT) nxt_p1OeN[`ECI_PIN] = 1'b1;
    for (int i = 0; i < NUM_MOD; i++) begin
      if (modMode_ff[i][`MM_TOG_BIT] | modMode_ff[i][`MM_PWM_BIT]) begin
        nxt_p1Out[`MODULE_PIN_BASE + i] = moduleOut[i];
        nxt_p1OeN[`MODULE_PIN_BASE + i] = 1'b0;
      end else if (modMode_ff[i][`MM_CAPN_BIT] | modMode_ff[i][`MM_CAPP_BIT]) begin
        nxt_p1OeN[`MODULE_PIN_BASE + i] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      p1Out_ff <= 8'hFF;
      p1OeN_ff <= 8'hFF;
    end else begin
      p1Out_ff <= nxt_p1Out;
      p1OeN_ff <= nxt_p1OeN;
    end
  end
  assign p1Out = p1Out_ff;
  assign p1OeN = p1OeN_ff;

  // checking helpers: cycles since the last tick under unchanged settings
  logic [3:0] gap_ff;
  logic       gapValid_ff;
  logic [3:0] cfg_ff;
  logic [3:0] cfgNow;
  logic [3:0] expGap;
  assign cfgNow = {tk.enable, tk.doubleSpeed, tk.srcSel};
  assign expGap = (tk.srcSel == SRC_DIV12) ?
                  (doubleSpeed ? 4'(`DIV_SLOW_X2 - 1) : 4'(`DIV_SLOW - 1)) :
                  (doubleSpeed ? 4'(`DIV_FAST_X2 - 1) : 4'(`DIV_FAST - 1));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      gap_ff      <= 4'h0;
      gapValid_ff <= 1'b0;
      cfg_ff      <= 4'h0;
    end else begin
      cfg_ff      <= cfgNow;
      gap_ff      <= tk.tick ? 4'h0 : gap_ff + 4'h1;
      gapValid_ff <= (cfgNow == cfg_ff) && (gapValid_ff || tk.tick);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  tick_rate_a: assert property (tk.tick && gapValid_ff && cfgNow == cfg_ff &&
      (tk.srcSel == SRC_DIV12 || tk.srcSel == SRC_DIV4) |-> gap_ff == expGap)
    else $error("internal count rate wrong");
  ext_tick_a: assert property (tk.srcSel == SRC_EXT && tk.enable && tk.eciPulse |-> tk.tick)
    else $error("external pulse not counted");
  t0_tick_a: assert property (tk.srcSel == SRC_T0 && tk.enable |-> tk.tick == tk.t0Pulse)
    else $error("timer 0 overflow not counted");
  run_stop_a: assert property (!tk.enable && !loWr && !hiWr |=> $stable(count_ff))
    else $error("counter moved while stopped");
  idle_halt_a: assert property (counterMode_ff[`MODE_IDLE_BIT] && idleMode |-> !tk.tick)
    else $error("counter ticked in idle");
  ovf_set_a: assert property (tk.tick && !loWr && !hiWr && count_ff == 16'hFFFF
      |=> ovf_ff && count_ff == 16'h0000)
    else $error("overflow not flagged on wrap");
  ovf_hold_a: assert property (ovf_ff && !(ctrlWr && pwdata[`CTRL_OVF_BIT]) |=> ovf_ff)
    else $error("overflow flag lost");
  flag_set_a: assert property (moduleEvent != '0
      |=> (modFlag_ff & $past(moduleEvent)) == $past(moduleEvent))
    else $error("module flag not set");
  irq_gate_a: assert property (!counterMode_ff[`MODE_OVFIE_BIT] && modFlag_ff == '0
      |=> !irq)
    else $error("interrupt without enabled source");
  irq_raise_a: assert property (ovf_ff && counterMode_ff[`MODE_OVFIE_BIT] &&
      irqMask_ff[`CTRL_OVF_BIT] |=> irq)
    else $error("enabled overflow gave no interrupt");
  eci_pin_a: assert property (tk.srcSel == SRC_EXT |=> p1OeN[`ECI_PIN])
    else $error("count input pin driven");
  rsv_zero_a: assert property ((counterMode_ff & ~`MODE_WR_MASK) == 8'h00)
    else $error("reserved mode bits set");

  ovf_seen_c: cover property (ovfEvent);
  irq_seen_c: cover property (!irq ##1 irq);
  ext_seen_c: cover property (tk.srcSel == SRC_EXT && tk.tick);
  idle_seen_c: cover property (run_ff && idleMode && counterMode_ff[`MODE_IDLE_BIT]);
endmodule // counter_array_time_base

// ==== testbench/port1_model.sv ====
`timescale 1ns/1ps
// far side of port 1: pins with pull-ups, count source wired to bit 2
module port1_model (
  input  wire logic [7:0] p1Out,
  input  wire logic [7:0] p1OeN,
  input  wire logic       extLevel,
  output logic      [7:0] p1In
);
  // a released pin floats to the pull-up, except bit 2 which the source drives
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p1In[i] = !p1OeN[i] ? p1Out[i] : ((i == 2) ? extLevel : 1'b1);
    end
  end
endmodule // port1_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`include "cta_defs.svh"
module testbench;
  import cta_pkg::*;
  logic        ref_clk;
  logic        rstn;
  logic [9:0]  paddr;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  p1In, gpioOut, gpioOeN, p1Out, p1OeN;
  logic        timer0Ovf, idleMode, doubleSpeed, extLevel, watchdogEnable, irq;
  logic [4:0]  moduleEvent, moduleOut;
  byte_t [4:0] moduleMode;
  logic [15:0] countValue;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  byte_t       rd;
  logic        err;

  counter_array_time_base counter_array_time_base_i (
    .ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .p1In(p1In), .gpioOut(gpioOut), .gpioOeN(gpioOeN),
    .p1Out(p1Out), .p1OeN(p1OeN), .timer0Ovf(timer0Ovf), .idleMode(idleMode),
    .doubleSpeed(doubleSpeed), .moduleEvent(moduleEvent), .moduleOut(moduleOut),
    .moduleMode(moduleMode), .countValue(countValue),
    .watchdogEnable(watchdogEnable), .irq(irq));
  port1_model port1_model_i (.p1Out(p1Out), .p1OeN(p1OeN), .extLevel(extLevel), .p1In(p1In));

  // free-running 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, well above the several hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input bit wr, input byte_t idx, input byte_t wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input byte_t idx, input byte_t exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, {8'h00, exp}, {8'h00, rd});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  function automatic int div_of(input logic sel, input logic ds);
    if (!sel) return ds ? `DIV_SLOW_X2 : `DIV_SLOW;
    return ds ? `DIV_FAST_X2 : `DIV_FAST;
  endfunction

  // edges until the count next moves; pre-edge sampling keeps gaps exact
  task automatic gap(output int n);
    logic [15:0] v;
    v = countValue;
    n = 0;
    while (countValue === v && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  initial begin
    int n, k;
    logic [15:0] v;
    byte_t m;
    k = $urandom(16);
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {timer0Ovf, idleMode, doubleSpeed, moduleEvent} = '0;
    extLevel = 1'b1;
    moduleOut = 5'($urandom);
    gpioOut = 8'($urandom);
    gpioOeN = 8'($urandom);
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    chk("count rst", 16'h0000, countValue);
    chk("oen rst", 16'h00FF, {8'h00, p1OeN});
    rdchk("ctrl rst", `IDX_COUNTER_CONTROL, `COUNTER_CTRL_RST);
    rdchk("mode rst", `IDX_COUNTER_MODE, `COUNTER_MODE_RST);
    rdchk("mask rst", `IDX_IRQ_MASK, `IRQ_MASK_RST);
    // unmapped index is refused
    apb(1'b0, 8'hF0, 8'h00);
    chk("unmapped err", 16'h0001, {15'h0, err});
    chk("unmapped data", 16'h0000, {8'h00, rd});
    // reserved mode bits always written as zero
    repeat (4) begin
      m = byte_t'($urandom) & `MODE_WR_MASK;
      apb(1'b1, `IDX_COUNTER_MODE, m);
      rdchk("mode rw", `IDX_COUNTER_MODE, m);
      chk("wdog en", {15'h0, m[6]}, {15'h0, watchdogEnable});
    end
    for (int i = 0; i < 5; i++) begin
      m = byte_t'($urandom) & `MM_WR_MASK;
      apb(1'b1, byte_t'(`IDX_MODULE_MODE0 + i), m);
      rdchk("mod mode", byte_t'(`IDX_MODULE_MODE0 + i), m);
      chk("mod out", {8'h0, m}, {8'h0, moduleMode[i]});
    end
    v = 16'($urandom);
    apb(1'b1, `IDX_COUNT_LO, v[7:0]);
    apb(1'b1, `IDX_COUNT_HI, v[15:8]);
    // the byte lands at the access edge; look one edge later
    cycles(1);
    chk("count load", v, countValue);
    rdchk("count hi", `IDX_COUNT_HI, v[15:8]);
    // spacing of ticks for both internal sources, both speeds
    for (int s = 0; s < 4; s++) begin
      doubleSpeed <= s[0];
      apb(1'b1, `IDX_COUNTER_MODE, {6'h00, s[1], 1'b0});
      apb(1'b1, `IDX_COUNTER_CONTROL, 8'h40);
      gap(n);
      gap(n);
      chk("tick gap", 16'(div_of(s[1], s[0])), 16'(n));
      apb(1'b1, `IDX_COUNTER_CONTROL, 8'h00);
    end
    cycles(2);
    v = countValue;
    cycles(40);
    chk("stopped", v, countValue);
    idleMode <= 1'b1;
    apb(1'b1, `IDX_COUNTER_MODE, 8'h82);
    apb(1'b1, `IDX_COUNTER_CONTROL, 8'h40);
    cycles(2);
    v = countValue;
    cycles(40);
    chk("idle halt", v, countValue);
    apb(1'b1, `IDX_COUNTER_MODE, 8'h02);
    cycles(40);
    chk("idle run", 16'h0001, {15'h0, (countValue - v >= 16'd9)});
    idleMode <= 1'b0;
    // timer 0 then external edges, kept 8 clocks apart
    for (int s = 2; s < 4; s++) begin
      apb(1'b1, `IDX_COUNTER_MODE, byte_t'(s << 1));
      k = $urandom_range(3, 9);
      // old source may tick at the mode edge, and the pin needs its release to settle
      cycles(4);
      v = countValue;
      repeat (k) begin
        if (s == 2) timer0Ovf <= 1'b1;
        else extLevel <= 1'b0;
        cycles(4);
        timer0Ovf <= 1'b0;
        extLevel <= 1'b1;
        cycles(4);
      end
      cycles(6);
      chk("edge count", 16'(k), countValue - v);
      if (s == 3) chk("eci released", 16'h0001, {15'h0, p1OeN[2]});
    end
    apb(1'b1, `IDX_COUNTER_CONTROL, 8'h00);
    // wrap from all ones
    apb(1'b1, `IDX_COUNT_LO, 8'hFE);
    apb(1'b1, `IDX_COUNT_HI, 8'hFF);
    apb(1'b1, `IDX_COUNTER_MODE, 8'h03);
    apb(1'b1, `IDX_COUNTER_CONTROL, 8'h40);
    n = 0;
    while (countValue !== 16'h0000 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    cycles(3);
    chk("ovf irq", 16'h0001, {15'h0, irq});
    rdchk("ovf flag", `IDX_COUNTER_CONTROL, 8'hC0);
    apb(1'b1, `IDX_COUNTER_MODE, 8'h02);
    cycles(2);
    chk("ovf gated", 16'h0000, {15'h0, irq});
    rdchk("flag kept", `IDX_COUNTER_CONTROL, 8'hC0);
    apb(1'b1, `IDX_COUNTER_CONTROL, 8'h80);
    rdchk("ovf clr", `IDX_COUNTER_CONTROL, 8'h00);
    // module events with random enable, then masked, then cleared
    for (int i = 0; i < 5; i++) begin
      m = byte_t'($urandom_range(0, 1));
      apb(1'b1, byte_t'(`IDX_MODULE_MODE0 + i), m);
      @(posedge ref_clk);
      moduleEvent <= 5'(1 << i);
      @(posedge ref_clk);
      moduleEvent <= 5'h00;
      cycles(2);
      chk("mod irq", {15'h0, m[0]}, {15'h0, irq});
      rdchk("mod flag", `IDX_COUNTER_CONTROL, byte_t'(1 << i));
      apb(1'b1, `IDX_IRQ_MASK, ~byte_t'(1 << i));
      cycles(2);
      chk("masked", 16'h0000, {15'h0, irq});
      apb(1'b1, `IDX_IRQ_MASK, 8'hFF);
      apb(1'b1, `IDX_COUNTER_CONTROL, byte_t'(1 << i));
      rdchk("flag clr", `IDX_COUNTER_CONTROL, 8'h00);
    end
    // pin ownership follows module mode
    for (int i = 0; i < 5; i++) begin
      moduleOut <= 5'($urandom);
      gpioOut <= 8'($urandom);
      gpioOeN <= 8'($urandom);
      // odd modules modulate, even ones toggle: both hand the pin over
      apb(1'b1, byte_t'(`IDX_MODULE_MODE0 + i), (i[0] ? 8'h02 : 8'h04));
      cycles(2);
      chk("tog pin", {14'h0, 1'b0, moduleOut[i]}, {14'h0, p1OeN[3+i], p1Out[3+i]});
      apb(1'b1, byte_t'(`IDX_MODULE_MODE0 + i), (i[0] ? 8'h10 : 8'h20));
      cycles(2);
      chk("cap oen", 16'h0001, {15'h0, p1OeN[3+i]});
      apb(1'b1, byte_t'(`IDX_MODULE_MODE0 + i), 8'h00);
      cycles(2);
      chk("gpio", {14'h0, gpioOeN[3+i], gpioOut[3+i]}, {14'h0, p1OeN[3+i], p1Out[3+i]});
    end
    wrap_up();
  end
endmodule // testbench
